// ==== ulpi_lp_defines.svh ====
`ifndef ULPI_LP_DEFINES_SVH
`define ULPI_LP_DEFINES_SVH

// ----------------------------------------------------------------------
// Register map (byte addresses on the APB bus)
// ----------------------------------------------------------------------
`define OFF_FUNC_CTRL      12'h000
`define OFF_IFACE_CTRL     12'h004
`define OFF_IRQ_RISE_EN    12'h008
`define OFF_IRQ_FALL_EN    12'h00c
`define OFF_STATUS         12'h010

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define FC_SUSPEND_N_BIT   6
`define IC_SERIAL6_BIT     0
`define IC_SERIAL3_BIT     1
`define IC_KEEP_CLK_BIT    3
`define IC_PULLUP_DIS_BIT  7
`define ST_SRC_LSB         0
`define ST_IRQ_BIT         4
`define ST_DIR_BIT         5
`define ST_CLK_RUN_BIT     6
`define ST_STOP_BIT        7

// Interrupt sources, one bit each
`define SRC_BUS_VALID      0
`define SRC_SESS_VALID     1
`define SRC_SESS_END       2
`define SRC_ID_GND         3
`define NUM_SRC            4

// ----------------------------------------------------------------------
// Reset values and constants
// ----------------------------------------------------------------------
`define IRQ_EN_RST         4'hf
`define DATA_IDLE          8'h00
`define DATA_ALL_OE        8'hff
`define DATA_SER6_OE       8'hf8
`define MIN_STOP_EDGES     3'h5
`define CLK_MHZ            125
`define START_TIME_NS      2000
`define START_CYCLES       ((`START_TIME_NS * `CLK_MHZ + 999) / 1000)
`define WAKE_CNT_W         9

`endif

// ==== ulpi_lp_pkg.sv ====
package ulpi_lp_pkg;
  `include "ulpi_lp_defines.svh"

  typedef enum logic [2:0] {
    ST_SYNC,
    ST_ENTER,
    ST_LOW,
    ST_SERIAL,
    ST_WAKE,
    ST_CLKUP,
    ST_RELEASE
  } ctrl_state_t;

  typedef struct packed {
    ctrl_state_t                st;
    logic                       dir;
    logic                       drive;
    logic                       clk_run;
    logic                       clk_div;
    logic [2:0]                 edges;
    logic [`WAKE_CNT_W-1:0]     wait_cnt;
    logic                       target_serial;
    logic                       suspend_n;
    logic                       serial6;
    logic                       serial3;
    logic                       keep_clk;
    logic                       pullup_dis;
    logic [`NUM_SRC-1:0]        rise_en;
    logic [`NUM_SRC-1:0]        fall_en;
    logic [31:0]                rdata;
    logic                       slverr;
  } ctrl_regs_t;

  typedef struct packed {
    logic [2:0] s;
    logic       q;
  } sync_regs_t;
endpackage

// ==== pin_sync.sv ====
`timescale 1ns/10ps
module pin_sync
  import ulpi_lp_pkg::*;
(
  // Clock and reset
  input  wire logic clock_in,
  input  wire logic rst_n_in,
  // Pin level
  input  wire logic pin_in,
  output logic      level_out
);
  sync_regs_t r;
  sync_regs_t r_nxt;

  // Accept a change once the second and third stages agree
  always_comb begin
    r_nxt     = r;
    r_nxt.s   = {r.s[1:0], pin_in};
    if (r.s[1] == r.s[2]) begin
      r_nxt.q = r.s[2];
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      r <= '0;
    end else begin
      r <= r_nxt;
    end
  end

  assign level_out = r.q;
endmodule

// ==== irq_latch.sv ====
`timescale 1ns/10ps
`include "ulpi_lp_defines.svh"
module irq_latch
  import ulpi_lp_pkg::*;
(
  // Clock and reset
  input  wire logic                clock_in,
  input  wire logic                rst_n_in,
  // Snapshot and sources
  input  wire logic                snap_in,
  input  wire logic [`NUM_SRC-1:0] live_async_in,
  input  wire logic [`NUM_SRC-1:0] live_sync_in,
  input  wire logic [`NUM_SRC-1:0] rise_en_in,
  input  wire logic [`NUM_SRC-1:0] fall_en_in,
  // Flag
  output logic                     irq_out
);
  logic [`NUM_SRC-1:0] latched_r;
  logic [`NUM_SRC-1:0] latched_nxt;
  logic [`NUM_SRC-1:0] hit;

  always_comb begin
    latched_nxt = snap_in ? live_sync_in : latched_r;
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      latched_r <= '0;
    end else begin
      latched_r <= latched_nxt;
    end
  end

  // Compare the live level against the state caught before DIR rose
  for (genvar i = 0; i < `NUM_SRC; i++) begin : g_src
    assign hit[i] = (live_async_in[i] & ~latched_r[i] & rise_en_in[i]) |
                    (~live_async_in[i] & latched_r[i] & fall_en_in[i]);
  end

  assign irq_out = |hit;
endmodule

// ==== ulpi_low_power_serial_mode_ctrl.sv ====
// The implementer's own choices: the address map and register access over APB.
`timescale 1ns/10ps
`include "ulpi_lp_defines.svh"
module ulpi_low_power_serial_mode_ctrl
  import ulpi_lp_pkg::*;
(
  // Clock and reset
  input  wire logic                clock_in,
  input  wire logic                rst_n_in,
  // APB slave
  input  wire logic                psel_in,
  input  wire logic                penable_in,
  input  wire logic                pwrite_in,
  input  wire logic [11:0]         paddr_in,
  input  wire logic [31:0]         pwdata_in,
  output logic [31:0]              prdata_out,
  output logic                     pready_out,
  output logic                     pslverr_out,
  // ULPI pins
  input  wire logic                stp_in,
  input  wire logic [7:0]          data_in,
  output logic [7:0]               data_out,
  output logic [7:0]               data_oe_out,
  output logic                     dir_out,
  output logic                     phy_clock_output_out,
  output logic                     stop_pullup_enable_out,
  // Analog front end
  input  wire logic [1:0]          linestate_in,
  input  wire logic                rx_diff_in,
  input  wire logic                rx_se0_in,
  input  wire logic [`NUM_SRC-1:0] cmp_level_in,
  output logic                     bus_power_valid_cmp_on_out,
  output logic                     session_end_cmp_on_out,
  output logic                     fs_tx_enable_out,
  output logic                     fs_tx_data_out,
  output logic                     fs_tx_se0_out
);
  ctrl_regs_t          r;
  ctrl_regs_t          r_nxt;
  logic                stp_s;
  logic [`NUM_SRC-1:0] cmp_s;
  logic                irq;
  logic                snap;
  logic                setup_ph;
  logic                wr_acc;
  logic                rising_next;
  logic                stop_ok;
  logic                tx_en;
  logic                ser3;
  logic                ser6;
  logic [7:0]          status;

  // ----------------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------------
  pin_sync u_stp_sync (
    .clock_in  (clock_in),
    .rst_n_in  (rst_n_in),
    .pin_in    (stp_in),
    .level_out (stp_s)
  );

  for (genvar i = 0; i < `NUM_SRC; i++) begin : g_cmp_sync
    pin_sync u_cmp_sync (
      .clock_in  (clock_in),
      .rst_n_in  (rst_n_in),
      .pin_in    (cmp_level_in[i]),
      .level_out (cmp_s[i])
    );
  end

  // ----------------------------------------------------------------------
  // Interrupt sources in low power and serial modes
  // ----------------------------------------------------------------------
  irq_latch u_irq (
    .clock_in      (clock_in),
    .rst_n_in      (rst_n_in),
    .snap_in       (snap),
    .live_async_in (cmp_level_in),
    .live_sync_in  (cmp_s),
    .rise_en_in    (r.rise_en),
    .fall_en_in    (r.fall_en),
    .irq_out       (irq)
  );

  // ----------------------------------------------------------------------
  // Helper terms
  // ----------------------------------------------------------------------
  assign setup_ph    = psel_in && !penable_in;
  assign wr_acc      = psel_in && penable_in && pwrite_in;
  assign rising_next = r.clk_run && !r.clk_div;
  assign stop_ok     = (r.edges >= `MIN_STOP_EDGES) && !r.clk_div;
  assign snap        = (r.st == ST_SYNC) && (!r.suspend_n || r.serial3 || r.serial6);
  assign ser3        = (r.st == ST_SERIAL) && r.serial3;
  assign ser6        = (r.st == ST_SERIAL) && !r.serial3;
  assign tx_en       = data_in[0];
  assign status      = {stp_s, r.clk_run, r.dir, irq, cmp_s};

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    r_nxt       = r;
    r_nxt.drive = r.dir;
    r_nxt.clk_div = r.clk_run ? !r.clk_div : 1'b0;

    // APB read data is captured in the setup phase
    if (setup_ph) begin
      r_nxt.slverr = 1'b0;
      r_nxt.rdata  = 32'h0000_0000;
      unique case (paddr_in)
        `OFF_FUNC_CTRL:   r_nxt.rdata[`FC_SUSPEND_N_BIT] = r.suspend_n;
        `OFF_IFACE_CTRL: begin
          r_nxt.rdata[`IC_SERIAL6_BIT]    = r.serial6;
          r_nxt.rdata[`IC_SERIAL3_BIT]    = r.serial3;
          r_nxt.rdata[`IC_KEEP_CLK_BIT]   = r.keep_clk;
          r_nxt.rdata[`IC_PULLUP_DIS_BIT] = r.pullup_dis;
        end
        `OFF_IRQ_RISE_EN: r_nxt.rdata[`NUM_SRC-1:0] = r.rise_en;
        `OFF_IRQ_FALL_EN: r_nxt.rdata[`NUM_SRC-1:0] = r.fall_en;
        `OFF_STATUS:      r_nxt.rdata[7:0] = status;
        default:          r_nxt.slverr = 1'b1;
      endcase
    end

    if (wr_acc) begin
      unique case (paddr_in)
        `OFF_FUNC_CTRL:   r_nxt.suspend_n = pwdata_in[`FC_SUSPEND_N_BIT];
        `OFF_IFACE_CTRL: begin
          r_nxt.serial6    = pwdata_in[`IC_SERIAL6_BIT];
          r_nxt.serial3    = pwdata_in[`IC_SERIAL3_BIT];
          r_nxt.keep_clk   = pwdata_in[`IC_KEEP_CLK_BIT];
          r_nxt.pullup_dis = pwdata_in[`IC_PULLUP_DIS_BIT];
        end
        `OFF_IRQ_RISE_EN: r_nxt.rise_en = pwdata_in[`NUM_SRC-1:0];
        `OFF_IRQ_FALL_EN: r_nxt.fall_en = pwdata_in[`NUM_SRC-1:0];
        default:          r_nxt.rise_en = r.rise_en;
      endcase
    end

    unique case (r.st)
      ST_SYNC: begin
        if (snap) begin
          r_nxt.st            = ST_ENTER;
          r_nxt.dir           = 1'b1;
          r_nxt.edges         = 3'h0;
          r_nxt.target_serial = r.suspend_n;
        end
      end
      ST_ENTER: begin
        if (rising_next && r.edges < `MIN_STOP_EDGES) begin
          r_nxt.edges = r.edges + 3'h1;
        end
        // Stop only with the output low and five rising edges seen
        if (stop_ok) begin
          r_nxt.st = r.target_serial ? ST_SERIAL : ST_LOW;
          if (!(r.target_serial && r.keep_clk)) begin
            r_nxt.clk_run = 1'b0;
            r_nxt.clk_div = 1'b0;
          end
        end
      end
      ST_LOW, ST_SERIAL: begin
        if (stp_s) begin
          r_nxt.st       = ST_WAKE;
          r_nxt.wait_cnt = '0;
        end
      end
      ST_WAKE: begin
        if (!stp_s) begin
          r_nxt.st = r.target_serial ? ST_SERIAL : ST_LOW;
        end else if (r.wait_cnt == `WAKE_CNT_W'(`START_CYCLES - 1)) begin
          r_nxt.st      = ST_CLKUP;
          r_nxt.clk_run = 1'b1;
        end else begin
          r_nxt.wait_cnt = r.wait_cnt + `WAKE_CNT_W'(1);
        end
      end
      ST_CLKUP: begin
        r_nxt.st  = ST_RELEASE;
        r_nxt.dir = 1'b0;
      end
      ST_RELEASE: begin
        // Hardware set wins over a software write in the same cycle
        if (!stp_s) begin
          r_nxt.st        = ST_SYNC;
          r_nxt.suspend_n = 1'b1;
          r_nxt.serial3   = 1'b0;
          r_nxt.serial6   = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      r            <= '0;
      r.st         <= ST_SYNC;
      r.clk_run    <= 1'b1;
      r.suspend_n  <= 1'b1;
      r.rise_en    <= `IRQ_EN_RST;
      r.fall_en    <= `IRQ_EN_RST;
    end else begin
      r <= r_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign prdata_out  = r.rdata;
  assign pready_out  = 1'b1;
  assign pslverr_out = r.slverr;

  assign dir_out                = r.dir;
  assign phy_clock_output_out   = r.clk_div;
  assign stop_pullup_enable_out = rst_n_in && !r.pullup_dis;

  assign bus_power_valid_cmp_on_out = r.rise_en[`SRC_BUS_VALID] |
                                      r.fall_en[`SRC_BUS_VALID];
  assign session_end_cmp_on_out     = r.rise_en[`SRC_SESS_END] |
                                      r.fall_en[`SRC_SESS_END];

  // Serial transmit pins go straight to the analog transmitter
  assign fs_tx_enable_out = (r.st == ST_SERIAL) && tx_en;
  assign fs_tx_data_out   = data_in[1];
  assign fs_tx_se0_out    = data_in[2];

  // Data bus is combinational in low power and serial since clocks stop
  always_comb begin
    data_out    = `DATA_IDLE;
    data_oe_out = '0;
    if (r.dir && r.drive) begin
      data_oe_out = `DATA_ALL_OE;
      if (r.st == ST_LOW) begin
        data_out = {4'h0, irq, 1'b0, linestate_in};
      end else if (ser3) begin
        data_out    = {4'h0, irq, ~rx_se0_in, rx_diff_in, 1'b0};
        data_oe_out = {5'h1f, ~tx_en, ~tx_en, 1'b0};
      end else if (ser6) begin
        data_out    = {1'b0, rx_diff_in, linestate_in[1], linestate_in[0], irq, 3'h0};
        data_oe_out = `DATA_SER6_OE;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);

  sequence s_entry_req;
    (r.st == ST_SYNC) && !r.suspend_n;
  endsequence

  sequence s_dir_up;
    dir_out && (data_oe_out == 8'h00) ##1 dir_out;
  endsequence

  a_pullup_reset_off: assert property (
    @(posedge clock_in) disable iff (1'b0) !rst_n_in |-> !stop_pullup_enable_out)
    else $error("STP pull-up enabled during reset");

  a_pullup_bit_ctrl: assert property (
    stop_pullup_enable_out == !r.pullup_dis)
    else $error("STP pull-up does not follow its disable bit");

  a_lp_entry_dir: assert property (
    s_entry_req |=> s_dir_up)
    else $error("DIR not raised with turnaround after suspend clear");

  a_clock_stop_edges: assert property (
    $fell(r.clk_run) |-> (r.edges == `MIN_STOP_EDGES) && dir_out && !phy_clock_output_out)
    else $error("Clock stopped before five rising edges");

  a_serial_clock_kept: assert property (
    (r.st == ST_ENTER) && r.target_serial && r.keep_clk |=> r.clk_run)
    else $error("Clock stopped in serial mode despite keep bit");

  a_clock_before_dir: assert property (
    $fell(dir_out) |-> r.clk_run && $past(r.clk_run))
    else $error("DIR dropped before the clock restarted");

  a_false_resume: assert property (
    (r.st == ST_WAKE) && !stp_s |=> dir_out && (r.st == ST_LOW || r.st == ST_SERIAL))
    else $error("Early STP release did not return to low power");

  a_exit_suspend_set: assert property (
    (r.st == ST_RELEASE) && !stp_s |=> r.suspend_n && (r.st == ST_SYNC))
    else $error("Suspend bit not set on exit");

  a_turnaround_gap: assert property (
    $changed(dir_out) |-> (data_oe_out == 8'h00) ##1 (dir_out == (data_oe_out != 8'h00)))
    else $error("Bus turnaround not one cycle");

  a_serial_upper_low: assert property (
    ser3 && r.drive |-> (data_out[7:4] == 4'h0) && (data_out[3] == irq))
    else $error("Three-pin upper data lines not low");

  a_cmp_power_off: assert property (
    !r.rise_en[`SRC_SESS_END] && !r.fall_en[`SRC_SESS_END] |-> !session_end_cmp_on_out)
    else $error("Session end comparator left powered");

  a_release_wait: assert property (
    (r.st == ST_RELEASE) && stp_s |=> (r.st == ST_RELEASE) && !dir_out)
    else $error("Left release before STP was released");

  a_clkup_then_dir: assert property (
    (r.st == ST_CLKUP) |-> r.clk_run ##1 !dir_out)
    else $error("DIR not dropped after the clock restart");

  a_lp_data_low: assert property (
    (r.st == ST_LOW) && r.drive |-> (data_out[7:4] == 4'h0) && !data_out[2] &&
      (data_out[3] == irq) && (data_oe_out == 8'hff))
    else $error("Low power data lines not in their mapping");
endmodule

// ==== ulpi_link_model.sv ====
`timescale 1ns/10ps
module ulpi_link_model (
  // Clock and reset
  input  wire logic       clock_in,
  input  wire logic       rst_n_in,
  // Bench commands
  input  wire logic       wake_in,
  input  wire logic       early_in,
  input  wire logic       float_in,
  input  wire logic       serial3_in,
  input  wire logic [2:0] serial_tx_in,
  // ULPI pins
  input  wire logic       dir_in,
  output logic            stp_out,
  output logic            stp_oe_out,
  output logic [7:0]      data_out,
  output logic [7:0]      data_oe_out
);
  typedef struct packed {
    logic       hold;
    logic       dir;
    logic [7:0] low;
    logic [7:0] age;
  } link_state_t;

  link_state_t state_r;
  link_state_t state_nxt;

  // ----------------------------------------
  // STP handshake
  // ----------------------------------------
  always_comb begin
    state_nxt = state_r;
    state_nxt.dir = dir_in;
    if (wake_in) begin
      state_nxt.hold = 1'b1;
      state_nxt.low = 8'h00;
      state_nxt.age = 8'h00;
    end else if (state_r.hold) begin
      state_nxt.age = state_r.age + 8'h01;
      if (!dir_in) begin
        state_nxt.low = state_r.low + 8'h01;
      end
      // Early release only when the bench asks for a false resume
      if (state_r.low == 8'h04 || (early_in && state_r.age == 8'h28)) begin
        state_nxt.hold = 1'b0;
      end
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_r <= '{hold: 1'b1, dir: 1'b1, low: 8'h00, age: 8'h00};
    end else begin
      state_r <= state_nxt;
    end
  end

  assign stp_out     = state_r.hold;
  assign stp_oe_out  = !float_in;
  assign data_out    = dir_in ? {5'h00, serial_tx_in} : 8'h00;
  assign data_oe_out = !rst_n_in ? 8'h00
    : !dir_in ? {8{!state_r.dir}}
    : serial3_in ? {5'h00, {2{serial_tx_in[0]}}, 1'b1} : 8'h00;
endmodule

// ==== ulpi_low_power_serial_mode_ctrl_test.sv ====
`timescale 1ns/10ps
`include "ulpi_lp_defines.svh"
module ulpi_low_power_serial_mode_ctrl_test;
  logic        clock_in;
  logic        rst_n_in = 1'b0;
  logic        psel_in = 1'b0;
  logic        penable_in = 1'b0;
  logic        pwrite_in = 1'b0;
  logic [11:0] paddr_in = 12'h000;
  logic [31:0] pwdata_in = 32'h0;
  logic [1:0]  linestate_in = 2'h0;
  logic        rx_diff_in = 1'b0;
  logic        rx_se0_in = 1'b0;
  logic [3:0]  cmp_level_in = 4'h0;
  logic [31:0] prdata_out;
  logic        pready_out, pslverr_out, dir_out, phy_clock_output_out;
  logic        stop_pullup_enable_out, bus_power_valid_cmp_on_out;
  logic        session_end_cmp_on_out, fs_tx_enable_out, fs_tx_data_out, fs_tx_se0_out;
  logic [7:0]  data_out, data_oe_out, lk_dat, lk_oe, data_w;
  logic        wake = 1'b0, early = 1'b0, flt = 1'b0, ser = 1'b0, s3 = 1'b0;
  logic [2:0]  stx = 3'h0;
  logic        lk_stp, lk_stp_oe, stp_w, stp_last = 1'b0, ck_q;
  logic [31:0] rq, v;
  logic        re;
  logic [3:0]  l0, rise, fall;
  int          seed = 98, err_count = 0, n_compared = 0, ck_edges = 0, cyc = 0, gap = 0;

  // Wire levels: data bus has pull-downs, STP has the switchable pull-up
  assign data_w = (data_oe_out & data_out) | (~data_oe_out & lk_oe & lk_dat);
  assign stp_w  = lk_stp_oe ? lk_stp : (stop_pullup_enable_out ? 1'b1 : ~stp_last);

  ulpi_low_power_serial_mode_ctrl dut_u (
    .clock_in, .rst_n_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in,
    .prdata_out, .pready_out, .pslverr_out, .stp_in(stp_w), .data_in(data_w), .data_out,
    .data_oe_out, .dir_out, .phy_clock_output_out, .stop_pullup_enable_out, .linestate_in,
    .rx_diff_in, .rx_se0_in, .cmp_level_in, .bus_power_valid_cmp_on_out,
    .session_end_cmp_on_out, .fs_tx_enable_out, .fs_tx_data_out, .fs_tx_se0_out);

  ulpi_link_model link_u (
    .clock_in, .rst_n_in, .wake_in(wake), .early_in(early), .float_in(flt),
    .serial3_in(s3), .serial_tx_in(stx), .dir_in(dir_out), .stp_out(lk_stp),
    .stp_oe_out(lk_stp_oe), .data_out(lk_dat), .data_oe_out(lk_oe));

  initial begin
    clock_in = 1'b0;
    forever #4 clock_in = ~clock_in;
  end

  task complete_run;
    $display("compared %0d mismatched %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task fail(input string m);
    err_count++;
    $display("BAD t=%0t %s", $time, m);
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_compared++;
    if (got !== exp) fail($sformatf("%s got %h exp %h", m, got, exp));
  endtask

  // ----------------------------------------
  // Bus, mode and interrupt helpers
  // ----------------------------------------
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock_in);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clock_in);
    penable_in <= 1'b1;
    @(posedge clock_in);
    while (pready_out !== 1'b1) @(posedge clock_in);
    rq = prdata_out;
    re = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask

  function automatic logic irq_f(input logic [3:0] l1);
    return |((l1 & ~l0 & rise) | (~l1 & l0 & fall));
  endfunction

  task wait_dir(input logic lvl, input int lim, output int n);
    n = 0;
    while (dir_out !== lvl && n < lim) begin
      @(negedge clock_in);
      n++;
    end
  endtask

  task enter(input logic [11:0] a, input logic [31:0] d, input logic keep);
    int n;
    int e0;
    apb(1'b1, a, d);
    e0 = ck_edges;
    wait_dir(1'b1, 8, n);
    chk(dir_out, 1'b1, "dir raise");
    repeat (40) @(negedge clock_in);
    chk(ck_edges - e0 >= 5, 1'b1, "edges before stop");
    e0 = ck_edges;
    repeat (10) @(negedge clock_in);
    chk(ck_edges == e0 && phy_clock_output_out === 1'b0, !keep, "clock stop");
    @(posedge clock_in);
    s3 <= a == `OFF_IFACE_CTRL;
  endtask

  task wake_t(input int mode);
    int n;
    int e0;
    @(posedge clock_in);
    s3 <= 1'b0;
    wake <= mode < 2;
    early <= mode == 1;
    flt <= mode == 2;
    @(posedge clock_in);
    wake <= 1'b0;
    e0 = ck_edges;
    wait_dir(1'b0, 700, n);
    if (mode == 1) begin
      chk(dir_out, 1'b1, "false resume");
    end else begin
      chk(n >= `START_CYCLES, 1'b1, "start-up time");
      repeat (8) @(negedge clock_in);
      chk(ck_edges - e0 >= 3, 1'b1, "clock restart");
      @(posedge clock_in);
      flt <= 1'b0;
      ser <= 1'b0;
      repeat (12) @(posedge clock_in);
      apb(1'b0, `OFF_FUNC_CTRL, 32'h0);
      chk(rq, 32'h40, "suspend bit");
    end
  endtask

  always @(negedge clock_in) begin
    if (phy_clock_output_out === 1'b1 && ck_q === 1'b0) ck_edges++;
    ck_q = phy_clock_output_out;
    stp_last = stp_w;
    gap = (rst_n_in && !ser && (data_oe_out | lk_oe) !== 8'hff) ? gap + 1 : 0;
    if (gap > 1) fail("bus undriven");
    if (rst_n_in && (data_oe_out & lk_oe) !== 8'h00) fail("bus contention");
    cyc++;
    if (cyc == 10000) begin
      fail("timeout");
      complete_run;
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (15) @(posedge clock_in);
    @(negedge clock_in);
    chk(stop_pullup_enable_out, 1'b0, "pullup in reset");
    @(posedge clock_in);
    rst_n_in <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, 12'(i * 4 + i / 4 * 12), 32'h0);
      chk(rq, i == 0 ? 32'h40 : (i == 2 || i == 3) ? 32'hf : 32'h0, "reset value");
      chk(re, i == 4, "slverr");
    end
    chk(stop_pullup_enable_out, 1'b1, "pullup on");
    apb(1'b1, `OFF_IFACE_CTRL, 32'h80);
    apb(1'b0, `OFF_IFACE_CTRL, 32'h0);
    chk({rq[7:0], stop_pullup_enable_out}, {8'h80, 1'b0}, "pullup off");
    apb(1'b1, `OFF_IFACE_CTRL, 32'h0);
    $display("registers done");
    for (int k = 0; k < 3; k++) begin
      v = $random(seed);
      rise = v[3:0];
      fall = v[7:4];
      l0 = v[11:8];
      apb(1'b1, `OFF_IRQ_RISE_EN, {28'h0, rise});
      apb(1'b1, `OFF_IRQ_FALL_EN, {28'h0, fall});
      cmp_level_in <= l0;
      @(negedge clock_in);
      chk({bus_power_valid_cmp_on_out, session_end_cmp_on_out},
          {rise[0] | fall[0], rise[2] | fall[2]}, "cmp power");
      repeat (6) @(posedge clock_in);
      enter(`OFF_FUNC_CTRL, 32'h0, 1'b0);
      cmp_level_in <= v[15:12];
      linestate_in <= v[17:16];
      repeat (3) @(negedge clock_in);
      chk(data_out, {4'h0, irq_f(v[15:12]), 1'b0, v[17:16]}, "lp data");
      chk(data_oe_out, 8'hff, "lp oe");
      repeat (2) @(posedge clock_in);
      apb(1'b0, `OFF_STATUS, 32'h0);
      chk(rq, {24'h0, 3'h1, irq_f(v[15:12]), v[15:12]}, "status");
      wake_t(k);
      if (k == 1) wake_t(0);
      $display("low power round done");
    end
    @(posedge clock_in);
    ser <= 1'b1;
    l0 = cmp_level_in;
    enter(`OFF_IFACE_CTRL, 32'h2, 1'b0);
    for (int i = 0; i < 8; i++) begin
      @(posedge clock_in);
      v = $random(seed);
      stx <= v[2:0];
      rx_diff_in <= v[3];
      rx_se0_in <= v[4];
      cmp_level_in <= v[8:5];
      repeat (3) @(negedge clock_in);
      chk(data_out[7:3], {4'h0, irq_f(v[8:5])}, "serial irq");
      chk({data_oe_out, fs_tx_enable_out}, {v[0] ? 8'hf8 : 8'hfe, v[0]}, "tx en");
      if (v[0]) chk({fs_tx_data_out, fs_tx_se0_out}, {v[1], v[2]}, "tx");
      else chk(data_out[2:1], {~v[4], v[3]}, "rx");
    end
    wake_t(0);
    @(posedge clock_in);
    ser <= 1'b1;
    l0 = cmp_level_in;
    enter(`OFF_IFACE_CTRL, 32'h1, 1'b0);
    cmp_level_in <= ~l0;
    repeat (3) @(negedge clock_in);
    chk({data_oe_out, data_out},
        {8'hf8, 1'b0, rx_diff_in, linestate_in, irq_f(~l0), 3'h0}, "six-pin");
    wake_t(0);
    $display("serial done");
    @(posedge clock_in);
    ser <= 1'b1;
    enter(`OFF_IFACE_CTRL, 32'ha, 1'b1);
    rst_n_in <= 1'b0;
    repeat (2) @(negedge clock_in);
    chk({dir_out, stop_pullup_enable_out}, 2'b00, "reset pulse");
    @(posedge clock_in);
    rst_n_in <= 1'b1;
    ser <= 1'b0;
    s3 <= 1'b0;
    apb(1'b0, `OFF_IFACE_CTRL, 32'h0);
    chk(rq, 32'h0, "serial cleared");
    $display("reset done");
    complete_run;
  end
endmodule
